//--- amv_regs.svh
/*
  timing, encodings and field constants for the acl mac/vlan/arp matcher.
  assumes inclusion by bare name from the design files.
*/
`ifndef AMV_REGS_SVH
`define AMV_REGS_SVH
`define AMV_ETYPE_MIN 16'h0600
`define AMV_ETYPE_ARP 16'h0806
`define AMV_ETYPE_RARP 16'h8035
`define AMV_OP_ARP_REQ 16'h0001
`define AMV_OP_ARP_REP 16'h0002
`define AMV_OP_RARP_REQ 16'h0003
`define AMV_OP_RARP_REP 16'h0004
`define AMV_HLN_ETH 8'h06
`define AMV_PLN_IP4 8'h04
`define AMV_HRD_ETH 16'h0001
`define AMV_PRO_IP4 16'h0800
`define AMV_MAC_BCAST 48'hffff_ffff_ffff
`define AMV_VID_MIN 12'h001
`define AMV_MCAST_BIT 40
`define AMV_MATCH_LATENCY 2
`endif

//--- amv_pkg.sv
/*
  types for the acl mac/vlan/arp matcher.
  assumes no other package.
*/
package amv_pkg;
  typedef enum logic [1:0] {
    AMV_FT_ANY = 2'b00,
    AMV_FT_ETYPE = 2'b01,
    AMV_FT_ARP = 2'b10,
    AMV_FT_OTHER = 2'b11
  } amv_ftype_type;
  typedef enum logic [2:0] {
    AMV_DM_ANY = 3'b000,
    AMV_DM_MCAST = 3'b001,
    AMV_DM_BCAST = 3'b010,
    AMV_DM_UCAST = 3'b011,
    AMV_DM_SPEC = 3'b100
  } amv_dmac_type;
  // shared tri-state setting: any, equal (1), differ (0)
  typedef enum logic [1:0] {
    AMV_TRI_ANY = 2'b00,
    AMV_TRI_ZERO = 2'b01,
    AMV_TRI_ONE = 2'b10
  } amv_tri_type;
  typedef enum logic [1:0] {
    AMV_OK_ANY = 2'b00,
    AMV_OK_ARP = 2'b01,
    AMV_OK_RARP = 2'b10,
    AMV_OK_OTHER = 2'b11
  } amv_opkind_type;
  typedef enum logic [1:0] {
    AMV_RR_ANY = 2'b00,
    AMV_RR_REQ = 2'b01,
    AMV_RR_REP = 2'b10
  } amv_reqrep_type;
  typedef enum logic [1:0] {
    AMV_IP_ANY = 2'b00,
    AMV_IP_HOST = 2'b01,
    AMV_IP_NET = 2'b10
  } amv_ipflt_type;
  typedef enum logic [1:0] {
    AMV_ST_IDLE = 2'b00,
    AMV_ST_EVAL = 2'b01,
    AMV_ST_DONE = 2'b10
  } amv_state_type;
endpackage : amv_pkg

//--- amv_frame_if.sv
/*
  parsed frame fields handed from the top to the arp field checker.
  assumes a single clock domain.
*/
interface amv_frame_if;
  logic [47:0] smac;
  logic [47:0] sha;
  logic [47:0] tha;
  logic [15:0] opcode;
  logic [15:0] hrd;
  logic [15:0] pro;
  logic [7:0] hln;
  logic [7:0] pln;
  logic [31:0] spa;
  logic [31:0] tpa;
  logic arp_ok;
  modport src (output smac, sha, tha, opcode, hrd, pro, hln, pln, spa, tpa, input arp_ok);
  modport chk (input smac, sha, tha, opcode, hrd, pro, hln, pln, spa, tpa, output arp_ok);
endinterface : amv_frame_if

//--- amv_ip_match.sv
/*
  sender or target ip criterion: any, host or masked network compare.
  assumes configuration is stable during a lookup.
*/
module amv_ip_match (
  // config
  input wire amv_pkg::amv_ipflt_type mode,
  input wire logic [31:0] cfg_addr,
  input wire logic [31:0] cfg_mask,
  // frame
  input wire logic [31:0] frame_addr,
  // result
  output wire logic ok
);
  wire logic host_eq;
  wire logic net_eq;
  assign host_eq = (frame_addr == cfg_addr);
  // mask both sides so stray host bits in the configured address are harmless
  assign net_eq = ((frame_addr & cfg_mask) == (cfg_addr & cfg_mask));
  assign ok = (mode == amv_pkg::AMV_IP_HOST) ? host_eq :
              (mode == amv_pkg::AMV_IP_NET) ? net_eq : 1'b1;
endmodule : amv_ip_match

//--- amv_arp_check.sv
/*
  arp/rarp header criteria of one entry, purely combinational.
  assumes the top gates the result with the arp frame-type selection.
*/
`include "amv_regs.svh"
module amv_arp_check (
  // frame fields
  amv_frame_if.chk frm,
  // config
  input wire amv_pkg::amv_opkind_type cfg_opkind,
  input wire amv_pkg::amv_reqrep_type cfg_reqrep,
  input wire amv_pkg::amv_ipflt_type cfg_sip_mode,
  input wire logic [31:0] cfg_sip_addr,
  input wire logic [31:0] cfg_sip_mask,
  input wire amv_pkg::amv_ipflt_type cfg_tip_mode,
  input wire logic [31:0] cfg_tip_addr,
  input wire logic [31:0] cfg_tip_mask,
  input wire amv_pkg::amv_tri_type cfg_sender_hw_consistency_check,
  input wire amv_pkg::amv_tri_type cfg_target_hw_consistency_check,
  input wire amv_pkg::amv_tri_type cfg_address_length_check,
  input wire amv_pkg::amv_tri_type cfg_hw_space_check,
  input wire amv_pkg::amv_tri_type cfg_proto_space_check
);
  function automatic logic tri_ok(input amv_pkg::amv_tri_type sel, input logic eq);
    case (sel)
      amv_pkg::AMV_TRI_ONE: tri_ok = eq;
      amv_pkg::AMV_TRI_ZERO: tri_ok = !eq;
      default: tri_ok = 1'b1;
    endcase
  endfunction : tri_ok

  wire logic is_arp_op;
  wire logic is_rarp_op;
  wire logic is_req;
  wire logic is_rep;
  wire logic op_ok;
  wire logic rr_ok;
  wire logic sip_ok;
  wire logic tip_ok;
  wire logic len_eq;
  assign is_arp_op = (frm.opcode == `AMV_OP_ARP_REQ) || (frm.opcode == `AMV_OP_ARP_REP);
  assign is_rarp_op = (frm.opcode == `AMV_OP_RARP_REQ) || (frm.opcode == `AMV_OP_RARP_REP);
  assign is_req = (frm.opcode == `AMV_OP_ARP_REQ) || (frm.opcode == `AMV_OP_RARP_REQ);
  assign is_rep = (frm.opcode == `AMV_OP_ARP_REP) || (frm.opcode == `AMV_OP_RARP_REP);
  assign op_ok = (cfg_opkind == amv_pkg::AMV_OK_ARP) ? is_arp_op :
                 (cfg_opkind == amv_pkg::AMV_OK_RARP) ? is_rarp_op :
                 (cfg_opkind == amv_pkg::AMV_OK_OTHER) ? !(is_arp_op || is_rarp_op) : 1'b1;
  assign rr_ok = (cfg_reqrep == amv_pkg::AMV_RR_REQ) ? is_req :
                 (cfg_reqrep == amv_pkg::AMV_RR_REP) ? is_rep : 1'b1;
  amv_ip_match u_sip (
    .mode(cfg_sip_mode),
    .cfg_addr(cfg_sip_addr),
    .cfg_mask(cfg_sip_mask),
    .frame_addr(frm.spa),
    .ok(sip_ok)
  );
  amv_ip_match u_tip (
    .mode(cfg_tip_mode),
    .cfg_addr(cfg_tip_addr),
    .cfg_mask(cfg_tip_mask),
    .frame_addr(frm.tpa),
    .ok(tip_ok)
  );
  assign len_eq = (frm.hln == `AMV_HLN_ETH) && (frm.pln == `AMV_PLN_IP4);
  assign frm.arp_ok = op_ok && rr_ok && sip_ok && tip_ok &&
    tri_ok(cfg_sender_hw_consistency_check, frm.sha == frm.smac) &&
    tri_ok(cfg_target_hw_consistency_check, frm.tha == frm.smac) &&
    tri_ok(cfg_address_length_check, len_eq) &&
    tri_ok(cfg_hw_space_check, frm.hrd == `AMV_HRD_ETH) &&
    tri_ok(cfg_proto_space_check, frm.pro == `AMV_PRO_IP4);
endmodule : amv_arp_check

//--- amv_matcher.sv
/*
  match logic of one access control entry: mac, vlan and arp criteria.
  assumes the parser presents all fields with frame_valid for one cycle,
  fields from the same clock domain, configuration stable during lookup.
*/
// Functional notes
// - source mac any or exact 48-bit match
// - destination class multicast, broadcast or unicast
// - destination mac specific needs exact match
// - mac criteria only for ethertype or arp
// - vlan id any or specific 1..4095
// - tag priority any or exact 0..7
// - arp criteria only for arp entries
// - opcode kind any, arp, rarp, other
// - request/reply any, request or reply
// - sender ip any, host or network
// - target ip any, host or network
// - sha versus source mac equal/differ/any
// - tha versus source mac equal/differ/any
// - hln 6 and pln 4 check
// - hrd equals ethernet check
// - ethertype class needs type >= 0x0600, not arp
// - hit with deny drops, else permit
`include "amv_regs.svh"
module amv_matcher (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // parsed frame
  input wire logic frame_valid,
  input wire logic [47:0] frame_dmac,
  input wire logic [47:0] frame_smac,
  input wire logic [15:0] frame_etype,
  input wire logic [11:0] frame_vid,
  input wire logic [2:0] frame_pcp,
  input wire logic [15:0] frame_arp_hrd,
  input wire logic [15:0] frame_arp_pro,
  input wire logic [7:0] frame_arp_hln,
  input wire logic [7:0] frame_arp_pln,
  input wire logic [15:0] frame_arp_op,
  input wire logic [47:0] frame_arp_sha,
  input wire logic [31:0] frame_arp_spa,
  input wire logic [47:0] frame_arp_tha,
  input wire logic [31:0] frame_arp_tpa,
  // entry configuration
  input wire logic cfg_enable,
  input wire amv_pkg::amv_ftype_type cfg_frame_type,
  input wire logic cfg_deny,
  input wire logic cfg_smac_specific,
  input wire logic [47:0] cfg_smac,
  input wire amv_pkg::amv_dmac_type cfg_dmac_mode,
  input wire logic [47:0] cfg_dmac,
  input wire logic cfg_vid_specific,
  input wire logic [11:0] cfg_vid,
  input wire logic cfg_pcp_specific,
  input wire logic [2:0] cfg_pcp,
  input wire amv_pkg::amv_opkind_type cfg_opkind,
  input wire amv_pkg::amv_reqrep_type cfg_reqrep,
  input wire amv_pkg::amv_ipflt_type cfg_sip_mode,
  input wire logic [31:0] cfg_sip_addr,
  input wire logic [31:0] cfg_sip_mask,
  input wire amv_pkg::amv_ipflt_type cfg_tip_mode,
  input wire logic [31:0] cfg_tip_addr,
  input wire logic [31:0] cfg_tip_mask,
  input wire amv_pkg::amv_tri_type cfg_sender_hw_consistency_check,
  input wire amv_pkg::amv_tri_type cfg_target_hw_consistency_check,
  input wire amv_pkg::amv_tri_type cfg_address_length_check,
  input wire amv_pkg::amv_tri_type cfg_hw_space_check,
  input wire amv_pkg::amv_tri_type cfg_proto_space_check,
  // result
  output logic result_valid,
  output logic hit,
  output logic permit,
  output logic drop,
  output logic busy
);
  // stage 1 registers: the frame is captured so the wide compares see a stable copy
  logic [47:0] dmac_reg;
  logic [47:0] smac_reg;
  logic [15:0] etype_reg;
  logic [11:0] vid_reg;
  logic [2:0] pcp_reg;
  logic [15:0] hrd_reg;
  logic [15:0] pro_reg;
  logic [7:0] hln_reg;
  logic [7:0] pln_reg;
  logic [15:0] op_reg;
  logic [47:0] sha_reg;
  logic [31:0] spa_reg;
  logic [47:0] tha_reg;
  logic [31:0] tpa_reg;
  amv_pkg::amv_state_type state_reg;
  amv_pkg::amv_state_type state_next;
  logic result_valid_reg;
  logic hit_reg;
  logic drop_reg;

  amv_frame_if frm ();

  always_ff @(posedge clk_sys) begin
    if (frame_valid) begin
      dmac_reg <= frame_dmac;
      smac_reg <= frame_smac;
      etype_reg <= frame_etype;
      vid_reg <= frame_vid;
      pcp_reg <= frame_pcp;
      hrd_reg <= frame_arp_hrd;
      pro_reg <= frame_arp_pro;
      hln_reg <= frame_arp_hln;
      pln_reg <= frame_arp_pln;
      op_reg <= frame_arp_op;
      sha_reg <= frame_arp_sha;
      spa_reg <= frame_arp_spa;
      tha_reg <= frame_arp_tha;
      tpa_reg <= frame_arp_tpa;
    end
  end

  assign frm.smac = smac_reg;
  assign frm.sha = sha_reg;
  assign frm.tha = tha_reg;
  assign frm.opcode = op_reg;
  assign frm.hrd = hrd_reg;
  assign frm.pro = pro_reg;
  assign frm.hln = hln_reg;
  assign frm.pln = pln_reg;
  assign frm.spa = spa_reg;
  assign frm.tpa = tpa_reg;

  amv_arp_check u_arp (
    .frm(frm.chk),
    .cfg_opkind(cfg_opkind),
    .cfg_reqrep(cfg_reqrep),
    .cfg_sip_mode(cfg_sip_mode),
    .cfg_sip_addr(cfg_sip_addr),
    .cfg_sip_mask(cfg_sip_mask),
    .cfg_tip_mode(cfg_tip_mode),
    .cfg_tip_addr(cfg_tip_addr),
    .cfg_tip_mask(cfg_tip_mask),
    .cfg_sender_hw_consistency_check(cfg_sender_hw_consistency_check),
    .cfg_target_hw_consistency_check(cfg_target_hw_consistency_check),
    .cfg_address_length_check(cfg_address_length_check),
    .cfg_hw_space_check(cfg_hw_space_check),
    .cfg_proto_space_check(cfg_proto_space_check)
  );

  // frame class decode
  wire logic frame_is_arp;
  wire logic frame_is_etype;
  wire logic type_ok;
  wire logic mac_crit_on;
  wire logic multicast_class_select;
  wire logic broadcast_class_select;
  wire logic unicast_class_select;
  wire logic smac_ok;
  wire logic dmac_ok;
  wire logic vid_ok;
  wire logic pcp_ok;
  wire logic arp_ok;
  wire logic hit_now;

  assign frame_is_arp = (etype_reg == `AMV_ETYPE_ARP) || (etype_reg == `AMV_ETYPE_RARP);
  // arp frames are kept out of the plain ethertype class
  assign frame_is_etype = (etype_reg >= `AMV_ETYPE_MIN) && !frame_is_arp;
  assign type_ok = (cfg_frame_type == amv_pkg::AMV_FT_ANY) ||
                   ((cfg_frame_type == amv_pkg::AMV_FT_ETYPE) && frame_is_etype) ||
                   ((cfg_frame_type == amv_pkg::AMV_FT_ARP) && frame_is_arp);
  assign mac_crit_on = (cfg_frame_type == amv_pkg::AMV_FT_ETYPE) ||
                       (cfg_frame_type == amv_pkg::AMV_FT_ARP);

  assign broadcast_class_select = (dmac_reg == `AMV_MAC_BCAST);
  // broadcast also has the group bit set, so it counts as multicast here
  assign multicast_class_select = dmac_reg[`AMV_MCAST_BIT];
  assign unicast_class_select = !dmac_reg[`AMV_MCAST_BIT];

  assign smac_ok = !mac_crit_on || !cfg_smac_specific || (smac_reg == cfg_smac);
  assign dmac_ok = !mac_crit_on ||
    ((cfg_dmac_mode == amv_pkg::AMV_DM_MCAST) ? multicast_class_select :
     (cfg_dmac_mode == amv_pkg::AMV_DM_BCAST) ? broadcast_class_select :
     (cfg_dmac_mode == amv_pkg::AMV_DM_UCAST) ? unicast_class_select :
     (cfg_dmac_mode == amv_pkg::AMV_DM_SPEC) ? (dmac_reg == cfg_dmac) : 1'b1);
  // vid 0 is not a legal specific setting and never hits
  assign vid_ok = !cfg_vid_specific ||
                  ((cfg_vid >= `AMV_VID_MIN) && (vid_reg == cfg_vid));
  assign pcp_ok = !cfg_pcp_specific || (pcp_reg == cfg_pcp);
  assign arp_ok = (cfg_frame_type != amv_pkg::AMV_FT_ARP) || frm.arp_ok;
  assign hit_now = cfg_enable && type_ok && smac_ok && dmac_ok && vid_ok &&
                   pcp_ok && arp_ok;

  // sequencer: idle, evaluate the captured frame, present the result
  always_comb begin
    case (state_reg)
      amv_pkg::AMV_ST_IDLE: state_next = frame_valid ? amv_pkg::AMV_ST_EVAL : amv_pkg::AMV_ST_IDLE;
      amv_pkg::AMV_ST_EVAL: state_next = amv_pkg::AMV_ST_DONE;
      amv_pkg::AMV_ST_DONE: state_next = frame_valid ? amv_pkg::AMV_ST_EVAL : amv_pkg::AMV_ST_IDLE;
      default: state_next = amv_pkg::AMV_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= amv_pkg::AMV_ST_IDLE;
      result_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      result_valid_reg <= (state_reg == amv_pkg::AMV_ST_EVAL);
      hit_reg <= (state_reg == amv_pkg::AMV_ST_EVAL) && hit_now;
      drop_reg <= (state_reg == amv_pkg::AMV_ST_EVAL) && hit_now && cfg_deny;
    end
  end

  assign result_valid = result_valid_reg;
  assign hit = hit_reg;
  assign drop = drop_reg;
  assign permit = hit_reg && !drop_reg;
  // a frame_valid while busy is refused; the parser must space lookups
  assign busy = (state_reg == amv_pkg::AMV_ST_EVAL);

  a_result_latency : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (frame_valid && !busy) |=> ##1 result_valid)
    else $error("result not two cycles after frame");
  a_hit_only_valid : assert property (@(posedge clk_sys) disable iff (!rst_b)
    hit |-> result_valid)
    else $error("hit without result valid");
  a_drop_is_deny : assert property (@(posedge clk_sys) disable iff (!rst_b)
    drop |-> (hit && $past(cfg_deny)))
    else $error("drop without deny hit");
  a_smac_spec_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && mac_crit_on && cfg_smac_specific && (smac_reg != cfg_smac)) |=> !hit)
    else $error("hit despite source mac mismatch");
  a_bcast_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && mac_crit_on && (cfg_dmac_mode == amv_pkg::AMV_DM_BCAST) &&
     (dmac_reg != `AMV_MAC_BCAST)) |=> !hit)
    else $error("hit on non-broadcast");
  a_vid_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && cfg_vid_specific && (vid_reg != cfg_vid)) |=> !hit)
    else $error("hit despite vid mismatch");
  a_pcp_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && cfg_pcp_specific && (pcp_reg != cfg_pcp)) |=> !hit)
    else $error("hit despite priority mismatch");
  a_arp_not_etype : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && frame_is_arp && (cfg_frame_type == amv_pkg::AMV_FT_ETYPE)) |=> !hit)
    else $error("arp frame hit ethertype entry");
  a_arp_gate : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && (cfg_frame_type == amv_pkg::AMV_FT_ARP) && !frm.arp_ok) |=> !hit)
    else $error("arp criteria ignored");
  a_short_type : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && (etype_reg < `AMV_ETYPE_MIN) && (cfg_frame_type == amv_pkg::AMV_FT_ETYPE))
    |=> !hit)
    else $error("length frame hit ethertype entry");

  // evaluation cycle of an arp entry, shared by the arp checks below
  wire logic arp_eval;
  assign arp_eval = busy && (cfg_frame_type == amv_pkg::AMV_FT_ARP);

  // a lookup passes one busy cycle and then one result cycle
  sequence s_taken;
    frame_valid && !busy;
  endsequence
  sequence s_answered;
    busy ##1 (result_valid && !busy);
  endsequence

  a_take_answer : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_taken |=> s_answered)
    else $error("lookup skipped busy or result");

  a_result_pulse : assert property (@(posedge clk_sys) disable iff (!rst_b)
    result_valid |=> !result_valid)
    else $error("result held two cycles");

  a_disabled_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && !cfg_enable) |=> !hit)
    else $error("disabled entry hit");

  a_mac_ignored : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && cfg_enable && (cfg_frame_type == amv_pkg::AMV_FT_ANY) && vid_ok && pcp_ok)
    |=> hit)
    else $error("open entry missed");

  a_dmac_spec_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && mac_crit_on && (cfg_dmac_mode == amv_pkg::AMV_DM_SPEC) && (dmac_reg != cfg_dmac))
    |=> !hit)
    else $error("hit despite dest mac mismatch");

  a_reqrep_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (arp_eval && (cfg_reqrep == amv_pkg::AMV_RR_REP) &&
     (op_reg != `AMV_OP_ARP_REP) && (op_reg != `AMV_OP_RARP_REP)) |=> !hit)
    else $error("reply entry hit non-reply");

  a_sip_host_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (arp_eval && (cfg_sip_mode == amv_pkg::AMV_IP_HOST) && (spa_reg != cfg_sip_addr))
    |=> !hit)
    else $error("hit despite sender ip mismatch");

  a_tip_net_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (arp_eval && (cfg_tip_mode == amv_pkg::AMV_IP_NET) &&
     (((tpa_reg ^ cfg_tip_addr) & cfg_tip_mask) != 32'h0000_0000)) |=> !hit)
    else $error("hit despite target net mismatch");

  a_sha_miss : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (arp_eval && (cfg_sender_hw_consistency_check == amv_pkg::AMV_TRI_ONE) &&
     (sha_reg != smac_reg)) |=> !hit)
    else $error("hit despite sender hw mismatch");
endmodule : amv_matcher

//--- amv_parser_model.sv
/*
  bench frame record and a model of the ingress parser feeding the matcher.
  assumes one clock; the caller never sends while the matcher is busy.
*/
package amv_tb_pkg;
  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [15:0] etype;
    logic [11:0] vid;
    logic [2:0] pcp;
    logic [15:0] hrd;
    logic [15:0] pro;
    logic [7:0] hln;
    logic [7:0] pln;
    logic [15:0] op;
    logic [47:0] sha;
    logic [31:0] spa;
    logic [47:0] tha;
    logic [31:0] tpa;
  } amv_frm_type;
endpackage : amv_tb_pkg

module amv_parser_model (
  // clock
  input wire logic clk_sys,
  // parsed frame
  output logic frame_valid,
  output amv_tb_pkg::amv_frm_type frm
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_valid = 1'b0;
    frm = '0;
  end
  // one-cycle pulse; fields are scrambled afterwards so stale capture is caught
  task automatic send(input amv_tb_pkg::amv_frm_type fr);
    @(negedge clk_sys);
    frame_valid = 1'b1;
    frm = fr;
    @(negedge clk_sys);
    frame_valid = 1'b0;
    frm = ~fr;
  endtask : send
endmodule : amv_parser_model

//--- tb_top.sv
/*
  self-checking bench of the acl matcher: table corners and seeded random.
  assumes the parser model and a 100 MHz clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, frame_valid, result_valid, hit, permit, drop, busy;
  amv_tb_pkg::amv_frm_type frm, f;
  logic cfg_enable, cfg_deny, cfg_smac_specific, cfg_vid_specific, cfg_pcp_specific;
  logic [47:0] cfg_smac, cfg_dmac;
  logic [11:0] cfg_vid;
  logic [2:0] cfg_pcp;
  logic [31:0] cfg_sip_addr, cfg_sip_mask, cfg_tip_addr, cfg_tip_mask;
  amv_pkg::amv_ftype_type cfg_frame_type;
  amv_pkg::amv_dmac_type cfg_dmac_mode;
  amv_pkg::amv_opkind_type cfg_opkind;
  amv_pkg::amv_reqrep_type cfg_reqrep;
  amv_pkg::amv_ipflt_type cfg_sip_mode, cfg_tip_mode;
  amv_pkg::amv_tri_type cfg_sender_hw_consistency_check, cfg_target_hw_consistency_check;
  amv_pkg::amv_tri_type cfg_address_length_check, cfg_hw_space_check, cfg_proto_space_check;
  int miscompares = 0;
  int check_count = 0;
  int unsigned seed = 66790;
  bit quiet;
  logic [15:0] ety [4] = '{16'h05ff, 16'h0600, 16'h0806, 16'h8035};

  amv_parser_model prs (.clk_sys(clk_sys), .frame_valid(frame_valid), .frm(frm));

  amv_matcher dut (.clk_sys, .rst_b, .frame_valid, .frame_dmac(frm.dmac), .frame_smac(frm.smac),
    .frame_etype(frm.etype), .frame_vid(frm.vid), .frame_pcp(frm.pcp), .frame_arp_hrd(frm.hrd),
    .frame_arp_pro(frm.pro), .frame_arp_hln(frm.hln), .frame_arp_pln(frm.pln),
    .frame_arp_op(frm.op), .frame_arp_sha(frm.sha), .frame_arp_spa(frm.spa),
    .frame_arp_tha(frm.tha), .frame_arp_tpa(frm.tpa), .cfg_enable, .cfg_frame_type, .cfg_deny,
    .cfg_smac_specific, .cfg_smac, .cfg_dmac_mode, .cfg_dmac, .cfg_vid_specific, .cfg_vid,
    .cfg_pcp_specific, .cfg_pcp, .cfg_opkind, .cfg_reqrep, .cfg_sip_mode, .cfg_sip_addr,
    .cfg_sip_mask, .cfg_tip_mode, .cfg_tip_addr, .cfg_tip_mask, .cfg_sender_hw_consistency_check,
    .cfg_target_hw_consistency_check, .cfg_address_length_check, .cfg_hw_space_check,
    .cfg_proto_space_check, .result_valid, .hit, .permit, .drop, .busy);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic int unsigned r32();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : r32
  function automatic int unsigned rnd(int unsigned n);
    return r32() % n;
  endfunction : rnd
  // criteria mostly left open so that random hits stay frequent
  function automatic int unsigned pick(int unsigned n);
    return (quiet || rnd(3) != 0) ? 0 : rnd(n);
  endfunction : pick
  function automatic logic tri_ok(amv_pkg::amv_tri_type t, logic eq);
    return t == amv_pkg::AMV_TRI_ANY || (t == amv_pkg::AMV_TRI_ONE) == eq;
  endfunction : tri_ok
  function automatic logic ip_ok(amv_pkg::amv_ipflt_type m, logic [31:0] a, c, k);
    if (m == amv_pkg::AMV_IP_HOST) return a == c;
    if (m == amv_pkg::AMV_IP_NET) return (a & k) == (c & k);
    return 1'b1;
  endfunction : ip_ok

  function automatic logic exp_hit();
    logic arp_et, opa, opr, cls, mac, arp;
    arp_et = f.etype == 16'h0806 || f.etype == 16'h8035;
    opa = f.op == 16'h0001 || f.op == 16'h0002;
    opr = f.op == 16'h0003 || f.op == 16'h0004;
    case (cfg_frame_type)
      amv_pkg::AMV_FT_ANY: cls = 1'b1;
      amv_pkg::AMV_FT_ETYPE: cls = f.etype >= 16'h0600 && !arp_et;
      amv_pkg::AMV_FT_ARP: cls = arp_et;
      default: cls = 1'b0;
    endcase
    mac = !cfg_smac_specific || f.smac == cfg_smac;
    case (cfg_dmac_mode)
      amv_pkg::AMV_DM_MCAST: mac &= f.dmac[40];
      amv_pkg::AMV_DM_BCAST: mac &= f.dmac == 48'hffff_ffff_ffff;
      amv_pkg::AMV_DM_UCAST: mac &= !f.dmac[40];
      amv_pkg::AMV_DM_SPEC: mac &= f.dmac == cfg_dmac;
      default: ;
    endcase
    case (cfg_opkind)
      amv_pkg::AMV_OK_ARP: arp = opa;
      amv_pkg::AMV_OK_RARP: arp = opr;
      amv_pkg::AMV_OK_OTHER: arp = !opa && !opr;
      default: arp = 1'b1;
    endcase
    if (cfg_reqrep == amv_pkg::AMV_RR_REQ) arp &= f.op == 16'h0001 || f.op == 16'h0003;
    if (cfg_reqrep == amv_pkg::AMV_RR_REP) arp &= f.op == 16'h0002 || f.op == 16'h0004;
    arp &= ip_ok(cfg_sip_mode, f.spa, cfg_sip_addr, cfg_sip_mask);
    arp &= ip_ok(cfg_tip_mode, f.tpa, cfg_tip_addr, cfg_tip_mask);
    arp &= tri_ok(cfg_sender_hw_consistency_check, f.sha == f.smac);
    arp &= tri_ok(cfg_target_hw_consistency_check, f.tha == f.smac);
    arp &= tri_ok(cfg_address_length_check, f.hln == 8'h06 && f.pln == 8'h04);
    arp &= tri_ok(cfg_hw_space_check, f.hrd == 16'h0001);
    arp &= tri_ok(cfg_proto_space_check, f.pro == 16'h0800);
    if (!(cfg_frame_type inside {amv_pkg::AMV_FT_ETYPE, amv_pkg::AMV_FT_ARP})) mac = 1'b1;
    if (cfg_frame_type != amv_pkg::AMV_FT_ARP) arp = 1'b1;
    return cfg_enable && cls && mac && arp
      && (!cfg_vid_specific || (f.vid == cfg_vid && cfg_vid != 12'h000))
      && (!cfg_pcp_specific || f.pcp == cfg_pcp);
  endfunction : exp_hit

  task automatic rand_frm();
    logic [351:0] big;
    for (int i = 0; i < 11; i++) big = {big[319:0], r32()};
    f = big[350:0];
    if (rnd(2)) f.etype = rnd(2) ? 16'h0806 : 16'h8035;
    if (rnd(4) == 0) f.etype = 16'h0600 - 16'(rnd(2));
    if (rnd(2)) f.op = 16'(rnd(6));
    if (rnd(2)) f.sha = f.smac;
    if (rnd(2)) f.tha = f.smac;
    if (rnd(2)) {f.hln, f.pln} = 16'h0604;
    if (rnd(2)) f.hrd = 16'h0001;
    if (rnd(2)) f.pro = 16'h0800;
    if (rnd(4) == 0) f.dmac = 48'hffff_ffff_ffff;
  endtask : rand_frm

  // values follow the frame half of the time; host vs net differ only in bit 0
  task automatic rand_cfg();
    cfg_enable = pick(8) != 7;
    cfg_deny = 1'(rnd(2));
    cfg_frame_type = amv_pkg::amv_ftype_type'(pick(4));
    cfg_smac_specific = 1'(pick(2));
    cfg_smac = rnd(2) ? f.smac : f.sha;
    cfg_dmac_mode = amv_pkg::amv_dmac_type'(pick(5));
    cfg_dmac = rnd(2) ? f.dmac : f.tha;
    cfg_vid_specific = 1'(pick(2));
    cfg_vid = rnd(2) ? f.vid : 12'(r32());
    cfg_pcp_specific = 1'(pick(2));
    cfg_pcp = f.pcp ^ 3'(rnd(2));
    cfg_opkind = amv_pkg::amv_opkind_type'(pick(4));
    cfg_reqrep = amv_pkg::amv_reqrep_type'(pick(3));
    cfg_sip_mode = amv_pkg::amv_ipflt_type'(pick(3));
    cfg_sip_addr = f.spa ^ 32'(rnd(2));
    cfg_sip_mask = rnd(2) ? 32'hffff_ff00 : 32'hffff_ffff;
    cfg_tip_mode = amv_pkg::amv_ipflt_type'(pick(3));
    cfg_tip_addr = f.tpa ^ 32'(rnd(2));
    cfg_tip_mask = rnd(2) ? 32'hffff_ff00 : 32'hffff_ffff;
    cfg_sender_hw_consistency_check = amv_pkg::amv_tri_type'(pick(3));
    cfg_target_hw_consistency_check = amv_pkg::amv_tri_type'(pick(3));
    cfg_address_length_check = amv_pkg::amv_tri_type'(pick(3));
    cfg_hw_space_check = amv_pkg::amv_tri_type'(pick(3));
    cfg_proto_space_check = amv_pkg::amv_tri_type'(pick(3));
  endtask : rand_cfg

  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // one lookup: result on the first edge after the taking edge, standing one cycle
  task automatic run();
    logic e;
    int n;
    e = exp_hit();
    prs.send(f);
    check({4'h0, busy}, 5'h01);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (result_valid !== 1'b1 && n < 8);
    if (n == 8) begin
      miscompares++;
      $display("ERROR %0t: no result", $time);
      results();
    end
    check(5'(n + 1), 5'h02);
    check({2'b00, hit, drop, permit}, {2'b00, e, e & cfg_deny, e & ~cfg_deny});
    @(negedge clk_sys);
    check({1'b0, result_valid, hit, drop, permit}, 5'h00);
  endtask : run

  initial begin
    rst_b = 1'b0;
    quiet = 1'b1;
    rand_frm();
    rand_cfg();
    repeat (16) @(negedge clk_sys);
    check({result_valid, hit, drop, permit, busy}, 5'h00);
    rst_b = 1'b1;
    for (int t = 0; t < 16; t++) begin
      rand_frm();
      rand_cfg();
      cfg_frame_type = amv_pkg::amv_ftype_type'(t / 4);
      f.etype = ety[t % 4];
      run();
    end
    $display("frame class table done");
    for (int t = 0; t < 72; t++) begin
      rand_frm();
      rand_cfg();
      cfg_frame_type = amv_pkg::AMV_FT_ARP;
      f.etype = 16'h0806;
      f.op = 16'(t % 6);
      cfg_opkind = amv_pkg::amv_opkind_type'(t / 18);
      cfg_reqrep = amv_pkg::amv_reqrep_type'((t / 6) % 3);
      run();
    end
    $display("opcode table done");
    for (int t = 0; t < 4; t++) begin
      rand_frm();
      rand_cfg();
      cfg_vid_specific = 1'b1;
      cfg_vid = t[1] ? 12'hfff : 12'h000;
      f.vid = cfg_vid ^ 12'(t[0]);
      run();
    end
    $display("vlan bounds done");
    quiet = 1'b0;
    repeat (400) begin
      rand_frm();
      rand_cfg();
      run();
    end
    $display("random lookups done");
    results();
  end
endmodule : tb_top
